// *** core/fsdp_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsdp_fifo #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("fsdp_fifo needs a power-of-two depth of two or more");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign push = in_valid_i && in_ready_o;
  assign pop  = (count != '0) && (!out_valid_o || out_ready_i);
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wptr] <= in_data_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Registered head word
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem[rptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** core/fsdp_pkg.sv ***
// Operation
// [RULE1] Any reset presets output data to all ones, drivers off, and issues a strobe.
// [RULE2] New output data is on the pins when the strobe falls.
// [RULE3] Bidirectional pins release their drivers shortly after the strobe rises.
// [RULE4] Strobe low time lies between 6.0 and 6.8 microseconds.
// [RULE5] Pins are sampled 10.5 to 12.5 microseconds after output data is written.
// [RULE6] Invert flag inverts all four sampled inputs before any further use.
// [RULE7] Delay mode reports a new input only after two equal consecutive samples.
// [RULE8] Delay mode blocks sampling for 256 microseconds minus 6.25 percent.
// [RULE9] Filter outputs are zero after reset and while exchange is inhibited.
// [RULE10] Delay mode: enable flag, gate flag, inverse param bit 1; never in safety.
// [RULE11] Delay activation uses the param bit 1 register, never the pin level.
// [RULE12] Sync mode uses same table with its own flags and param bit 2.
// [RULE13] Sync trigger: exchange call address lower than previous good call's.
// [RULE14] Trigger updates outputs only if armed by good data; always samples.
// [RULE15] Lowest-address slave postpones outputs one cycle, returns inputs at once.
// [RULE16] First exchange call after port activation is processed immediately.
// [RULE17] Param bit 2 falling under gating enables sync; next call immediate.
// [RULE18] Param bit 2 rising disables sync and drops an armed output event.
// [RULE19] Three own calls in a row suspend sync; another address resumes it.
// [RULE20] Output-only pins echo the received output data in the response.
// [RULE21] Sync mode keeps the strobe and the standard sample and output timing.
// [RULE22] Master keeps a stable output image per cycle and splits A and B slaves.
// [RULE23] First parameter write after reset clears the exchange inhibit.
// [RULE24] Strobe is active low, idles high, one pulse per output event.
package fsdp_pkg;
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned CNT_W          = 12;
  localparam int unsigned HOLDOFF_W      = 17;
  localparam int unsigned STB_LOW_MIN_NS = 6000;
  localparam int unsigned HOLD_MIN_NS    = 200;
  localparam int unsigned SAMPLE_MIN_NS  = 10500;
  localparam int unsigned HOLDOFF_US     = 256;
  localparam int unsigned HOLDOFF_TOL_DIV = 16;
  localparam int unsigned HOLDOFF_MIN_NS =
    HOLDOFF_US * 1000 - HOLDOFF_US * 1000 / HOLDOFF_TOL_DIV;
  localparam logic [CNT_W-1:0] STB_CYC =
    CNT_W'((STB_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] HOLD_CYC =
    CNT_W'((HOLD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] SAMPLE_CYC =
    CNT_W'((SAMPLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned HOLDOFF_CYC_DEF =
    (HOLDOFF_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] DATA_RESET  = 4'hF;
  localparam logic       PARAM_RESET = 1'h1;
  localparam logic [1:0] OWN_RUN_MAX = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOW  = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_PUSH = 4'b1000
  } fsdp_state_t;
endpackage

// *** core/fsdp_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsdp_port
  import fsdp_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYC = HOLDOFF_CYC_DEF,
  parameter int unsigned RESP_DEPTH  = 8
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // Configuration
  input  wire logic       invert_i,
  input  wire logic       filter_en_i,
  input  wire logic       filter_gate_by_param_i,
  input  wire logic       sync_en_i,
  input  wire logic       sync_gate_by_param_i,
  input  wire logic       safety_mode_i,
  input  wire logic [3:0] out_only_i,
  input  wire logic [4:0] own_addr_i,
  // Protocol engine calls
  input  wire logic       exchange_call_i,
  input  wire logic [4:0] call_addr_i,
  input  wire logic       call_ok_i,
  input  wire logic [3:0] call_data_i,
  input  wire logic       param_write_call_i,
  input  wire logic       param_bit_1_i,
  input  wire logic       param_bit_2_i,
  output logic            exchange_ready_o,
  output logic            exchange_enabled_o,
  // Response words
  output logic            resp_valid_o,
  input  wire logic       resp_ready_i,
  output logic [3:0]      resp_data_o,
  // Data pins, open drain
  input  wire logic [3:0] port_pin_i,
  output logic      [3:0] port_pin_o,
  output logic      [3:0] port_pin_oe_o,
  output logic            output_strobe_n_o
);
  if (HOLDOFF_CYC < 1 || HOLDOFF_CYC >= (1 << HOLDOFF_W)) begin : g_chk
    $error("fsdp_port hold-off count out of range");
  end
  localparam int A_HOLD = int'(HOLD_CYC);

  fsdp_state_t          st;
  logic [CNT_W-1:0]     cnt;
  logic [3:0]           pin_meta;
  logic [3:0]           pin_sync;
  logic                 param_1;
  logic                 param_2;
  logic                 inhibit;
  logic [3:0]           out_reg;
  logic                 op_resp;
  logic [3:0]           last_call;
  logic [3:0]           samp;
  logic [3:0]           prev_samp;
  logic [3:0]           filt;
  logic [HOLDOFF_W-1:0] holdoff;
  logic [4:0]           prev_addr;
  logic                 have_prev;
  logic                 armed;
  logic [3:0]           arm_data;
  logic                 first_pending;
  logic                 suspended;
  logic [1:0]           own_run;
  logic                 fifo_in_ready;
  logic                 push;
  logic [3:0]           push_data;

  logic       filter_on;
  logic       sync_on;
  logic       call_ev;
  logic       is_own;
  logic       own_ok;
  logic       trig;
  logic       immediate;
  logic       fire;
  logic       start;
  logic       start_strobe;
  logic [3:0] start_data;
  logic       start_resp;
  logic       sample_ev;
  logic       sample_taken;
  logic [3:0] raw;
  logic [3:0] reported;
  logic       p2_fall;
  logic       p2_rise;

  // Activation tables from the parameter registers only
  assign filter_on = filter_en_i && !safety_mode_i
                     && (!filter_gate_by_param_i || !param_1); // [RULE10] [RULE11]
  assign sync_on = sync_en_i && !safety_mode_i
                   && (!sync_gate_by_param_i || !param_2)
                   && !suspended; // [RULE12]

  always_comb begin
    call_ev   = exchange_call_i && !inhibit;
    is_own    = (call_addr_i == own_addr_i);
    own_ok    = call_ev && is_own && call_ok_i && exchange_ready_o;
    trig      = call_ev && call_ok_i && have_prev
                && (call_addr_i < prev_addr); // [RULE13]
    immediate = own_ok && (!sync_on || first_pending); // [RULE16]
    fire      = sync_on && !first_pending && trig
                && (st == ST_IDLE);
    start        = immediate || fire;
    start_strobe = immediate || armed; // [RULE14]
    start_data   = immediate ? call_data_i : arm_data;
    start_resp   = own_ok; // [RULE15]
    p2_fall   = param_write_call_i && param_2 && !param_bit_2_i;
    p2_rise   = param_write_call_i && !param_2 && param_bit_2_i;
  end

  // Input path
  assign raw = pin_sync ^ {4{invert_i}}; // [RULE6]
  assign sample_ev = (st == ST_WAIT) && (cnt == SAMPLE_CYC + 1'b1); // [RULE5]
  assign sample_taken = sample_ev && !(filter_on && holdoff != '0); // [RULE8]
  assign reported = filter_on ? filt : samp;
  assign push_data = (reported & ~out_only_i)
                     | ((own_ok ? call_data_i : last_call)
                        & out_only_i); // [RULE20]
  assign push = ((st == ST_PUSH) && op_resp)
                || (own_ok && !start); // [RULE15]
  assign port_pin_o = 4'h0;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= port_pin_i;
      pin_sync <= pin_meta;
    end
  end

  // Parameter registers and exchange inhibit
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      param_1 <= PARAM_RESET;
      param_2 <= PARAM_RESET;
      inhibit <= 1'b1;
    end else if (param_write_call_i) begin
      param_1 <= param_bit_1_i; // [RULE11]
      param_2 <= param_bit_2_i;
      inhibit <= 1'b0; // [RULE23]
    end
  end

  // Output event sequencer
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st                <= ST_LOW; // [RULE1]
      cnt               <= '0;
      out_reg           <= DATA_RESET; // [RULE1]
      port_pin_oe_o     <= 4'h0;
      output_strobe_n_o <= 1'b0; // [RULE1]
      op_resp           <= 1'b0;
    end else begin
      unique case (st)
        ST_IDLE: begin
          if (start) begin
            st      <= ST_LOW;
            cnt     <= '0;
            op_resp <= start_resp;
            if (start_strobe) begin
              output_strobe_n_o <= 1'b0; // [RULE24] [RULE21]
              out_reg           <= start_data;
              port_pin_oe_o     <= ~start_data; // [RULE2]
            end
          end
        end
        ST_LOW: begin
          cnt <= cnt + 1'b1;
          if (cnt == STB_CYC - 1'b1) begin
            output_strobe_n_o <= 1'b1; // [RULE4]
            st                <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          cnt <= cnt + 1'b1;
          if (cnt == STB_CYC + HOLD_CYC - 1'b1) begin
            port_pin_oe_o <= port_pin_oe_o & out_only_i; // [RULE3]
          end
          if (sample_ev) begin
            st <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  // Sampling, delay filter and hold-off
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      samp      <= 4'h0;
      prev_samp <= 4'h0;
      filt      <= 4'h0;
      holdoff   <= '0;
    end else begin
      if (holdoff != '0) begin
        holdoff <= holdoff - 1'b1;
      end
      if (sample_taken) begin
        samp      <= raw;
        prev_samp <= raw;
        if (filter_on) begin
          holdoff <= HOLDOFF_W'(HOLDOFF_CYC); // [RULE8]
          if (raw == prev_samp) begin
            filt <= raw; // [RULE7]
          end
        end
      end
      if (inhibit) begin
        filt <= 4'h0; // [RULE9]
      end
    end
  end

  // Trigger tracking, arming and suspension
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      prev_addr     <= 5'h00;
      have_prev     <= 1'b0;
      armed         <= 1'b0;
      arm_data      <= DATA_RESET;
      first_pending <= 1'b1;
      suspended     <= 1'b0;
      own_run       <= 2'h0;
      last_call     <= 4'h0;
    end else begin
      if (call_ev && call_ok_i) begin
        prev_addr <= call_addr_i;
        have_prev <= 1'b1;
      end
      if (own_ok) begin
        last_call <= call_data_i;
      end
      if (fire) begin
        armed <= 1'b0; // [RULE14]
      end
      if (own_ok && !immediate) begin
        armed    <= 1'b1;
        arm_data <= call_data_i;
      end
      if (immediate) begin
        first_pending <= 1'b0;
      end
      if (call_ev) begin
        if (is_own) begin
          if (own_run != OWN_RUN_MAX) begin
            own_run <= own_run + 1'b1;
          end
          if (own_run == OWN_RUN_MAX - 1'b1) begin
            suspended <= 1'b1; // [RULE19]
            armed     <= 1'b0;
          end
        end else begin
          own_run <= 2'h0;
          if (suspended) begin
            suspended     <= 1'b0; // [RULE19]
            first_pending <= 1'b1;
          end
        end
      end
      if (p2_fall && sync_gate_by_param_i) begin
        first_pending <= 1'b1; // [RULE17]
      end
      if (p2_rise) begin
        armed <= 1'b0; // [RULE18]
      end
      if (param_write_call_i && inhibit) begin
        first_pending <= 1'b1; // [RULE16]
      end
    end
  end

  // Handshake status
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      exchange_ready_o   <= 1'b0;
      exchange_enabled_o <= 1'b0;
    end else begin
      exchange_ready_o   <= (st == ST_IDLE) && !start && !push
                            && fifo_in_ready && !inhibit;
      exchange_enabled_o <= !inhibit;
    end
  end

  fsdp_fifo #(
    .WIDTH (4),
    .DEPTH (RESP_DEPTH)
  ) u_resp_fifo (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data),
    .out_valid_o (resp_valid_o),
    .out_ready_i (resp_ready_i),
    .out_data_o  (resp_data_o)
  );

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_reset_release;
    $rose(resetn_i);
  endsequence
  sequence s_strobe_rise;
    $rose(output_strobe_n_o);
  endsequence
  sequence s_three_own;
    call_ev && is_own && own_run == OWN_RUN_MAX - 1'b1;
  endsequence

  property p_reset_preset;
    s_reset_release |-> out_reg == DATA_RESET && port_pin_oe_o == 4'h0
      && !output_strobe_n_o;
  endproperty
  a_reset_preset: assert property (p_reset_preset) // [RULE1]
    else $error("reset did not preset the data port");

  property p_data_at_fall;
    $fell(output_strobe_n_o) |-> port_pin_oe_o == ~out_reg;
  endproperty
  a_data_at_fall: assert property (p_data_at_fall) // [RULE2]
    else $error("output data not on pins at strobe fall");

  property p_release;
    s_strobe_rise |-> ##[1:A_HOLD] (port_pin_oe_o & ~out_only_i) == 4'h0;
  endproperty
  a_release: assert property (p_release) // [RULE3]
    else $error("bidirectional driver not released in time");

  property p_strobe_width;
    s_strobe_rise |-> cnt == STB_CYC;
  endproperty
  a_strobe_width: assert property (p_strobe_width) // [RULE4]
    else $error("strobe low time wrong");

  property p_sample_time;
    sample_ev |-> st == ST_WAIT && output_strobe_n_o
      && cnt == SAMPLE_CYC + 1'b1;
  endproperty
  a_sample_time: assert property (p_sample_time) // [RULE5]
    else $error("sample outside acceptance window");

  property p_invert;
    sample_taken |=> samp == ($past(pin_sync) ^ {4{$past(invert_i)}});
  endproperty
  a_invert: assert property (p_invert) // [RULE6]
    else $error("sampled input not inverted as configured");

  property p_filter_hold;
    sample_taken && filter_on && raw != prev_samp && !inhibit
      |=> $stable(filt);
  endproperty
  a_filter_hold: assert property (p_filter_hold) // [RULE7]
    else $error("filter accepted a single sample");

  property p_holdoff;
    filter_on && holdoff != '0 |-> !sample_taken;
  endproperty
  a_holdoff: assert property (p_holdoff) // [RULE8]
    else $error("sample taken during hold-off");

  property p_filt_zero;
    inhibit |=> filt == 4'h0;
  endproperty
  a_filt_zero: assert property (p_filt_zero) // [RULE9]
    else $error("filter output not zero while inhibited");

  property p_p2_rise;
    p2_rise |=> !armed && !fire;
  endproperty
  a_p2_rise: assert property (p_p2_rise) // [RULE18]
    else $error("armed event kept after sync disable");

  property p_no_fire_unarmed;
    fire && !immediate && !armed |=> output_strobe_n_o;
  endproperty
  a_no_fire_unarmed: assert property (p_no_fire_unarmed) // [RULE14]
    else $error("strobe issued without armed data");

  property p_suspend;
    s_three_own |=> suspended && !armed;
  endproperty
  a_suspend: assert property (p_suspend) // [RULE19]
    else $error("sync mode not suspended after own calls");
endmodule
`default_nettype wire

// *** verification/fsdp_sensor_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsdp_sensor_model (
  // Device side of the open-drain pins
  input  wire logic [3:0] pin_oe_i,
  // Sensor contacts, high = pulling low
  input  wire logic [3:0] ext_low_i,
  // Resulting pin levels
  output logic      [3:0] pin_level_o
);
  // Pull-up wins unless either side pulls low; level follows both inputs at once
  assign pin_level_o = ~(pin_oe_i | ext_low_i);
endmodule
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fsdp_pkg::*;
  logic       ref_clk, resetn, inv, fen, fgate, sen, sgate, safety;
  logic       exch, cok, pw, p1, p2, rdy, en, rv, rr, stb;
  logic [3:0] out_only, cdata, rd, pin, pin_o, oe, ext;
  logic [4:0] own, caddr;
  int         num_errors = 0;
  int         num_checks = 0;
  int         n;
  logic [3:0] w;

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  fsdp_port #(.HOLDOFF_CYC(200), .RESP_DEPTH(8)) dut (
    .ref_clk_i(ref_clk), .resetn_i(resetn), .invert_i(inv),
    .filter_en_i(fen), .filter_gate_by_param_i(fgate), .sync_en_i(sen),
    .sync_gate_by_param_i(sgate), .safety_mode_i(safety),
    .out_only_i(out_only), .own_addr_i(own), .exchange_call_i(exch),
    .call_addr_i(caddr), .call_ok_i(cok), .call_data_i(cdata),
    .param_write_call_i(pw), .param_bit_1_i(p1), .param_bit_2_i(p2),
    .exchange_ready_o(rdy), .exchange_enabled_o(en), .resp_valid_o(rv),
    .resp_ready_i(rr), .resp_data_o(rd), .port_pin_i(pin),
    .port_pin_o(pin_o), .port_pin_oe_o(oe), .output_strobe_n_o(stb));

  fsdp_sensor_model u_model (
    .pin_oe_i(oe), .ext_low_i(ext), .pin_level_o(pin));

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic give_up(input string what);
    chk(what, 16'h0, 16'h1);
    end_of_test();
  endtask

  task automatic wait_stb(input logic lvl, input int bound, output int k);
    k = 0;
    while (stb !== lvl) begin
      if (k == bound) give_up("strobe wait");
      cyc(1);
      k++;
    end
  endtask

  task automatic xcall(input logic [4:0] a, input logic [3:0] d);
    int k;
    k = 0;
    while (a == own && rdy !== 1'b1) begin
      if (k == 4000) give_up("ready wait");
      cyc(1);
      k++;
    end
    @(posedge ref_clk);
    exch  <= 1'b1;
    caddr <= a;
    cdata <= d;
    @(posedge ref_clk);
    exch <= 1'b0;
    #1;
  endtask

  task automatic pwrite(input logic b1, input logic b2);
    @(posedge ref_clk);
    pw <= 1'b1;
    p1 <= b1;
    p2 <= b2;
    @(posedge ref_clk);
    pw <= 1'b0;
    cyc(2);
  endtask

  task automatic get_resp(input int bound, output logic [3:0] v);
    int k;
    k = 0;
    while (rv !== 1'b1) begin
      if (k == bound) give_up("response wait");
      cyc(1);
      k++;
    end
    v = rd;
    @(posedge ref_clk);
    rr <= 1'b1;
    @(posedge ref_clk);
    rr <= 1'b0;
    #1;
  endtask

  // One immediate exchange, timed at the pins, response compared if asked
  task automatic t_op(input logic [3:0] d, input logic [3:0] exp,
                      input bit cmp);
    int k;
    logic [3:0] v;
    xcall(own, d);
    wait_stb(1'b0, 4, k);
    chk("oe at strobe fall", oe, 4'(~d));
    wait_stb(1'b1, 1700, k);
    chk("strobe low cycles", k, 1500);
    k = 0;
    while (k < 300 && (oe & ~out_only) !== 4'h0) begin
      cyc(1);
      k++;
    end
    chk("bidir release", (k >= 50 && k <= 250), 1);
    get_resp(1200, v);
    if (cmp) chk("response", v, exp);
  endtask

  // Sync mode: resume, arm, fire on lower address, lowest-slave case,
  // then drop an armed event
  task automatic t_sync();
    pwrite(1'b1, 1'b0);
    xcall(5'h02, 4'h0);
    chk("no strobe on resume", stb, 1'b1);
    t_op(4'h9, 4'hF, 1);
    xcall(own, 4'h6);
    get_resp(10, w);
    chk("echo while armed", w, 4'h7);
    chk("no strobe while armed", stb, 1'b1);
    xcall(5'h02, 4'h0);
    wait_stb(1'b0, 4, n);
    chk("oe at trigger", oe, 4'(~4'h6));
    wait_stb(1'b1, 1700, n);
    chk("sync strobe low", n, 1500);
    cyc(1200);
    chk("no trigger response", rv, 1'b0);
    xcall(own, 4'h1);
    get_resp(10, w);
    chk("input sampled at trigger", w, 4'h7);
    xcall(5'h09, 4'h0);
    xcall(own, 4'h2);
    wait_stb(1'b0, 4, n);
    chk("oe lowest slave", oe, 4'(~4'h1));
    get_resp(2700, w);
    chk("lowest slave response", w, 4'h7);
    pwrite(1'b1, 1'b1);
    xcall(5'h01, 4'h0);
    n = 0;
    while (n < 100 && stb === 1'b1) begin
      cyc(1);
      n++;
    end
    chk("dropped event strobe", n, 100);
    chk("dropped event oe", oe, 4'h8);
  endtask

  initial begin
    resetn = 1'b0;
    inv = 1'b0;
    fen = 1'b1;
    fgate = 1'b1;
    sen = 1'b1;
    sgate = 1'b1;
    safety = 1'b0;
    exch = 1'b0;
    cok = 1'b1;
    pw = 1'b0;
    p1 = 1'b1;
    p2 = 1'b1;
    rr = 1'b0;
    ext = 4'h5;
    out_only = 4'h8;
    own = 5'h05;
    caddr = 5'h00;
    cdata = 4'h0;
    cyc(16);
    @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(1);
    chk("oe after reset", oe, 4'h0);
    wait_stb(1'b1, 1700, n);
    chk("reset strobe", (n >= 1499 && n <= 1501), 1);
    cyc(1500);
    chk("no reset response", rv, 1'b0);
    chk("inhibited", en, 1'b0);
    pwrite(1'b1, 1'b1);
    chk("enabled", en, 1'b1);
    chk("strobe idle", stb, 1'b1);
    t_op(4'h3, 4'h2, 1);
    inv <= 1'b1;
    t_op(4'hC, 4'hD, 1);
    inv <= 1'b0;
    pwrite(1'b0, 1'b1);
    ext <= 4'h0;
    t_op(4'h0, 4'h0, 0);
    t_op(4'h0, 4'h7, 1);
    ext <= 4'h7;
    t_op(4'h0, 4'h7, 1);
    t_op(4'h0, 4'h0, 1);
    pwrite(1'b1, 1'b1);
    ext <= 4'h0;
    t_sync();
    end_of_test();
  end
endmodule
`default_nettype wire
